// ---- logic/dram_ctl_pkg.sv ----
package dram_ctl_pkg;
	// ------------------------------------------------------------
	// Clock and cycle timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	// Times measured from the start of a memory cycle; data valid counts from row strobe, tap 120 from column strobe
	localparam int ROW_STROBE_NS = 130;
	localparam int ADDR_SWITCH_NS = 160;
	localparam int COL_STROBE_NS = 190;
	localparam int ACK_NS = 190;
	localparam int DATA_VALID_NS = 150;
	localparam int TAP_120_NS = 120;
	// Least times round up, so each figure uses a ceiling
	localparam int ROW_STROBE_CYC = (ROW_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_SWITCH_CYC = (ADDR_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COL_STROBE_CYC = (COL_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_CYC = (ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_VALID_CYC = ROW_STROBE_CYC
		+ (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_120_CYC = COL_STROBE_CYC + (TAP_120_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Refresh
	// ------------------------------------------------------------
	localparam int REFRESH_DIV = 144;
	localparam int GRANT_HOLD_CYC = 2;
	localparam int KERNEL_TOP_LSB = 19;
	localparam int BASE_SEL_BIT = 21;
	localparam logic [7:0] REFRESH_ROW_RST = 8'h00;
	// ------------------------------------------------------------
	// Register map over the plain register port
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h1;
	localparam logic [3:0] BUS_STAT_ADDR = 4'h2;
	localparam logic [3:0] ADDR_STAT_ADDR = 4'h3;
	localparam int CTRL_ERR_EN_BIT = 0;
	localparam int CTRL_PAR_EN_BIT = 1;
	localparam int CTRL_BAD_PAR_BIT = 2;
	localparam int STAT_PAR_BIT = 0;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// ------------------------------------------------------------
	// Cycle states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CPU = 4'b0010,
		ST_REFRESH = 4'b0100,
		ST_END = 4'b1000
	} cycle_state_e;
endpackage : dram_ctl_pkg

// ---- logic/byte_parity.sv ----
// ------------------------------------------------------------
// One byte lane: odd parity generation and check
// ------------------------------------------------------------
module byte_parity
	import dram_ctl_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Data and parity
	input wire logic [WIDTH-1:0] data_i,
	input wire logic seed_i,
	input wire logic stored_par_i,
	// Results
	output logic gen_par_o,
	output logic check_bad_o
);
	initial begin
		if (WIDTH < 1) begin
			$error("byte_parity width must be positive");
		end
	end

	// High when the byte holds an even number of ones with the seed high, or an odd number with the seed low
	assign gen_par_o = ~(^data_i) ^ ~seed_i;
	// High when byte plus stored bit is not odd
	assign check_bad_o = ~(^{data_i, stored_par_i});
endmodule : byte_parity

// ---- logic/dram_parity_mmu_refresh.sv ----
// What this block does
// - Row strobe at 130 ns, address switch at 160 ns, column strobe at 190 ns.
// - Read data counts valid no sooner than 150 ns after row strobe.
// - Data transceivers on only in column time with address bit 21 low.
// - Acknowledge at 190 ns on base access without grant or master select.
// - Stop timing at tap 120, then map-update enable, then end row timing.
// - On writes make one parity bit per byte giving odd parity.
// - On reads a bad byte in either selected lane (byte_sel_i) raises the parity fault.
// - Parity fault interrupts level 7 only with error enable set.
// - No parity fault when column strobe inhibited or on DMA accesses.
// - A parity fault captures bus and general status.
// - Write page status on error-free accesses with update and column enable.
// - Referenced flag to 1, bit0 0 on clean read, write-enable from mode.
// - Page fault when both flags zero on user or DMA access.
// - Management error on fault, user kernel access, or user unwritable page.
// - Management error interrupts level 7 only with error enable set.
// - Bus error, with error enable set, on CPU fault, user non-RAM, user bad write, user kernel write.
// - An illegal access inhibits the column strobe.
// - Refresh all 256 rows by RAS-only cycles every 36864 clocks (about 295 us).
// - Refresh request every 144 processor clocks.
// - Eight-bit row counter advances per grant and drives A3-A10.
// - On grant hold acknowledge two clocks and strobe all rows.
module dram_parity_mmu_refresh
	import dram_ctl_pkg::*;
#(
	parameter int ADDR_W = 23,
	parameter int ROW_BANKS = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Processor bus
	input wire logic processor_data_strobe_i,
	input wire logic rd_wr_i,
	input wire logic supervisor_access_bit_i,
	input wire logic [ADDR_W:1] addr_i,
	input wire logic ram_space_i,
	input wire logic bitmap_ref_i,
	input wire logic dma_access_i,
	input wire logic bus_master_select_n_i,
	input wire logic [15:0] wr_data_i,
	input wire logic [15:0] ram_data_i,
	input wire logic upper_byte_parity_i,
	input wire logic lower_byte_parity_i,
	input wire logic [1:0] byte_sel_i,
	// Page status from the map
	input wire logic page_status_bit0_i,
	input wire logic page_referenced_flag_i,
	input wire logic latched_page_write_enable_i,
	// Arbiter
	input wire logic refresh_grant_n_i,
	input wire logic common_grant_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// DRAM control
	output logic [ROW_BANKS-1:0] row_strobe_n_o,
	output logic column_strobe_gate_n_o,
	output logic addr_col_sel_o,
	output logic xcvr_en_n_o,
	output logic xcvr_dir_rd_o,
	output logic [7:0] refresh_row_o,
	output logic refresh_addr_en_o,
	output logic upper_byte_parity_o,
	output logic lower_byte_parity_o,
	output logic [15:0] rd_data_o,
	output logic rd_data_valid_o,
	// Processor answers
	output logic dtack_n_o,
	output logic bus_error_n_o,
	output logic level7_irq_n_o,
	output logic parity_fault_n_o,
	output logic translation_error_n_o,
	// Page status update
	output logic page_status_write_n_o,
	output logic map_update_enable_o,
	output logic new_page_status_bit0_o,
	output logic new_page_referenced_flag_o,
	output logic new_page_write_enable_o,
	// Refresh arbitration
	output logic refresh_request_n_o,
	output logic grant_ack_n_o
);
	initial begin
		if (ROW_BANKS < 1 || ADDR_W < 22) begin
			$error("dram_parity_mmu_refresh parameters out of range");
		end
	end

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	cycle_state_e state_reg, state_next;
	logic [5:0] tick_reg;
	logic [7:0] div_reg, row_reg;
	logic req_pend_reg, status_frozen_reg;
	logic [1:0] hold_reg;
	logic [2:0] ctrl_reg, sticky_reg;
	logic [15:0] bus_stat_reg, addr_stat_reg;
	wire cpu_start = processor_data_strobe_i & ~bitmap_ref_i & common_grant_n_i;
	wire in_cpu = (state_reg == ST_CPU);
	wire in_ref = (state_reg == ST_REFRESH);
	wire base_mem = ~addr_i[BASE_SEL_BIT];
	wire user_cpu = ~supervisor_access_bit_i & ~dma_access_i;
	wire is_write = ~rd_wr_i;
	wire kernel_area = (addr_i[KERNEL_TOP_LSB+2:KERNEL_TOP_LSB] == 3'h0);
	wire tap_120 = in_cpu & (tick_reg == 6'(TAP_120_CYC));
	wire at_col = in_cpu & (tick_reg == 6'(COL_STROBE_CYC));
	// Page checks
	wire flags_clear = ~page_status_bit0_i & ~page_referenced_flag_i;
	wire page_fault = flags_clear & (user_cpu | dma_access_i);
	wire mmu_err = page_fault | (user_cpu & kernel_area)
		| (user_cpu & ~latched_page_write_enable_i);
	wire berr = (page_fault & ~dma_access_i) | (user_cpu & ~ram_space_i)
		| (user_cpu & is_write & ~latched_page_write_enable_i)
		| (user_cpu & is_write & kernel_area);
	wire illegal = mmu_err | berr;
	wire col_ok = ~illegal & ram_space_i;
	// Parity lanes
	logic up_gen, lo_gen, up_bad, lo_bad;
	wire seed = ~ctrl_reg[CTRL_BAD_PAR_BIT];
	byte_parity #(.WIDTH(8)) up_lane (
		.data_i(is_write ? wr_data_i[15:8] : ram_data_i[15:8]),
		.seed_i(seed),
		.stored_par_i(upper_byte_parity_i),
		.gen_par_o(up_gen),
		.check_bad_o(up_bad)
	);
	byte_parity #(.WIDTH(8)) lo_lane (
		.data_i(is_write ? wr_data_i[7:0] : ram_data_i[7:0]),
		.seed_i(seed),
		.stored_par_i(lower_byte_parity_i),
		.gen_par_o(lo_gen),
		.check_bad_o(lo_bad)
	);
	wire par_err = rd_wr_i & ((up_bad & byte_sel_i[1]) | (lo_bad & byte_sel_i[0]))
		& col_ok & ~dma_access_i & ctrl_reg[CTRL_PAR_EN_BIT];
	wire par_evt = at_col & base_mem & par_err;

	// State transitions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (!refresh_grant_n_i && !common_grant_n_i) begin
					state_next = ST_REFRESH;
				end else if (cpu_start) begin
					state_next = ST_CPU;
				end
			end
			ST_CPU: begin
				if (tap_120) begin
					state_next = ST_END;
				end
			end
			ST_REFRESH: begin
				if (tick_reg == 6'(COL_STROBE_CYC)) begin
					state_next = ST_END;
				end
			end
			ST_END: begin
				if (!processor_data_strobe_i && common_grant_n_i) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State and cycle counter
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			tick_reg <= 6'h00;
		end else begin
			state_reg <= state_next;
			tick_reg <= (state_next != state_reg) ? 6'h01 : tick_reg + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// Strobes and data path
	// ------------------------------------------------------------
	wire row_on = (in_cpu | in_ref) & (tick_reg >= 6'(ROW_STROBE_CYC));
	wire col_on = in_cpu & (tick_reg >= 6'(COL_STROBE_CYC)) & col_ok & base_mem;
	// Refresh strobes every bank, a processor cycle only the addressed one
	wire [ROW_BANKS-1:0] row_next = in_ref ? ~{ROW_BANKS{row_on}}
		: ~(ROW_BANKS'(row_on) << (addr_i[1] % ROW_BANKS));

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			row_strobe_n_o <= '1;
			column_strobe_gate_n_o <= 1'b1;
			addr_col_sel_o <= 1'b0;
			xcvr_en_n_o <= 1'b1;
			xcvr_dir_rd_o <= 1'b1;
			dtack_n_o <= 1'b1;
			rd_data_o <= 16'h0000;
			rd_data_valid_o <= 1'b0;
			upper_byte_parity_o <= 1'b0;
			lower_byte_parity_o <= 1'b0;
		end else begin
			row_strobe_n_o <= row_next;
			column_strobe_gate_n_o <= ~col_on;
			addr_col_sel_o <= in_cpu & (tick_reg >= 6'(ADDR_SWITCH_CYC));
			xcvr_en_n_o <= ~col_on;
			xcvr_dir_rd_o <= rd_wr_i;
			// Answer at 190 ns for base memory with no grant and no master select
			dtack_n_o <= ~(in_cpu & (tick_reg >= 6'(ACK_CYC)) & base_mem
				& common_grant_n_i & bus_master_select_n_i) | (state_next != ST_CPU);
			// Array data is taken only after the access time has passed
			rd_data_valid_o <= in_cpu & rd_wr_i & (tick_reg >= 6'(DATA_VALID_CYC));
			if (in_cpu && rd_wr_i && tick_reg == 6'(DATA_VALID_CYC)) begin
				rd_data_o <= ram_data_i;
			end
			upper_byte_parity_o <= up_gen;
			lower_byte_parity_o <= lo_gen;
		end
	end

	// ------------------------------------------------------------
	// Map update and error reporting
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			map_update_enable_o <= 1'b0;
			page_status_write_n_o <= 1'b1;
			new_page_status_bit0_o <= 1'b0;
			new_page_referenced_flag_o <= 1'b0;
			new_page_write_enable_o <= 1'b0;
			translation_error_n_o <= 1'b1;
			bus_error_n_o <= 1'b1;
			parity_fault_n_o <= 1'b1;
			level7_irq_n_o <= 1'b1;
		end else begin
			map_update_enable_o <= tap_120;
			// Page status is written only on an error-free access in column time
			page_status_write_n_o <= ~(tap_120 & ~mmu_err & col_on);
			new_page_referenced_flag_o <= 1'b1;
			new_page_status_bit0_o <= ~(rd_wr_i & ~mmu_err);
			new_page_write_enable_o <= supervisor_access_bit_i & ~dma_access_i;
			translation_error_n_o <= ~(in_cpu & mmu_err);
			bus_error_n_o <= ~(in_cpu & berr & ctrl_reg[CTRL_ERR_EN_BIT]);
			if (par_evt) begin
				parity_fault_n_o <= 1'b0;
			end else if (state_next == ST_IDLE) begin
				parity_fault_n_o <= 1'b1;
			end
			level7_irq_n_o <= ~(ctrl_reg[CTRL_ERR_EN_BIT]
				& (~parity_fault_n_o | (in_cpu & mmu_err)));
		end
	end

	// ------------------------------------------------------------
	// Refresh timer, row counter and grant hold
	// ------------------------------------------------------------
	wire div_end = (div_reg == 8'(REFRESH_DIV - 1));
	wire grant_take = (state_reg == ST_IDLE) & (state_next == ST_REFRESH);
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_reg <= 8'h00;
			req_pend_reg <= 1'b0;
			row_reg <= REFRESH_ROW_RST;
			hold_reg <= 2'h0;
			refresh_request_n_o <= 1'b1;
			grant_ack_n_o <= 1'b1;
			refresh_row_o <= REFRESH_ROW_RST;
			refresh_addr_en_o <= 1'b0;
		end else begin
			div_reg <= div_end ? 8'h00 : div_reg + 8'h01;
			// Request held until grant; a new tick in that cycle wins
			if (div_end) begin
				req_pend_reg <= 1'b1;
			end else if (grant_take) begin
				req_pend_reg <= 1'b0;
			end
			refresh_request_n_o <= ~((req_pend_reg & ~grant_take) | div_end);
			if (grant_take) begin
				row_reg <= row_reg + 8'h01;
				hold_reg <= 2'(GRANT_HOLD_CYC);
			end else if (hold_reg != 2'h0) begin
				hold_reg <= hold_reg - 2'h01;
			end
			grant_ack_n_o <= ~(grant_take | (hold_reg > 2'h1));
			refresh_row_o <= grant_take ? row_reg : refresh_row_o;
			refresh_addr_en_o <= (state_next == ST_REFRESH);
		end
	end

	// ------------------------------------------------------------
	// Registers: control, sticky status and captured bus status
	// ------------------------------------------------------------
	wire stat_clr = reg_wr_i & (reg_addr_i == STATUS_ADDR);
	wire [2:0] evt = {in_cpu & berr, in_cpu & mmu_err, par_evt};
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= CTRL_RST;
			sticky_reg <= 3'h0;
			status_frozen_reg <= 1'b0;
			bus_stat_reg <= 16'h0000;
			addr_stat_reg <= 16'h0000;
		end else begin
			if (reg_wr_i && reg_addr_i == CTRL_ADDR) begin
				ctrl_reg <= reg_wdata_i[2:0];
			end
			// Set wins over a clear in the same cycle
			sticky_reg <= (stat_clr ? (sticky_reg & ~reg_wdata_i[2:0]) : sticky_reg) | evt;
			if (par_evt && !status_frozen_reg) begin
				bus_stat_reg <= {translation_error_n_o, dma_access_i, 4'hF, ~byte_sel_i,
					addr_i[ADDR_W], addr_i[ADDR_W-1], addr_i[21:16]};
				addr_stat_reg <= {addr_i[15:1], 1'b0};
				status_frozen_reg <= 1'b1;
			end else if (stat_clr) begin
				status_frozen_reg <= 1'b0;
			end
		end
	end

	// Read mux
	wire [15:0] rd_mux = (reg_addr_i == CTRL_ADDR) ? {13'h0000, ctrl_reg} :
		(reg_addr_i == STATUS_ADDR) ? {13'h0000, sticky_reg} :
		(reg_addr_i == BUS_STAT_ADDR) ? bus_stat_reg :
		(reg_addr_i == ADDR_STAT_ADDR) ? addr_stat_reg : 16'h0000;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence cpu_begin_s;
		state_reg == ST_IDLE && state_next == ST_CPU;
	endsequence
	row_time_a: assert property (
		cpu_begin_s |-> ##(ROW_STROBE_CYC + 1) (row_strobe_n_o != '1 || !in_cpu))
		else $error("row strobe late");
	col_never_early_a: assert property (
		!column_strobe_gate_n_o |-> $past(tick_reg) >= 6'(COL_STROBE_CYC))
		else $error("column strobe early");
	xcvr_base_a: assert property (!xcvr_en_n_o |-> !column_strobe_gate_n_o)
		else $error("transceivers outside column time");
	refresh_gap_a: assert property (div_end |=> !div_end [*8])
		else $error("refresh ticks too close");
	req_hold_a: assert property ((req_pend_reg && !grant_take) |=> !refresh_request_n_o)
		else $error("refresh request dropped before grant");
	grant_ack_a: assert property (
		grant_take |=> !grant_ack_n_o ##1 !grant_ack_n_o ##1 grant_ack_n_o)
		else $error("grant acknowledge not two clocks");
	row_adv_a: assert property (grant_take |=> row_reg == $past(row_reg) + 8'h01)
		else $error("refresh row did not advance");
	illegal_col_a: assert property ((at_col && illegal) |=> column_strobe_gate_n_o)
		else $error("column strobe on illegal access");
	parity_gen_a: assert property (
		(is_write && seed) |=> upper_byte_parity_o == ~(^$past(wr_data_i[15:8])))
		else $error("write parity wrong");
	map_write_a: assert property (!page_status_write_n_o |-> map_update_enable_o)
		else $error("status write without update enable");
endmodule : dram_parity_mmu_refresh

// ---- verification/refresh_arbiter_model.sv ----
// ------------------------------------------------------------
// Bus arbiter stand-in for refresh requests
// ------------------------------------------------------------
module refresh_arbiter_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Test control: grant only when enabled, after delay_i cycles
	input wire logic enable_i,
	input wire logic [7:0] delay_i,
	// Refresh handshake
	input wire logic refresh_request_n_i,
	input wire logic grant_ack_n_i,
	output logic refresh_grant_n_o,
	output logic common_grant_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] wait_reg;
	logic acked_reg;
	// Grant pending request, drop grants as soon as acknowledge ends
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wait_reg <= 8'h00;
			acked_reg <= 1'b0;
			refresh_grant_n_o <= 1'b1;
			common_grant_n_o <= 1'b1;
		end else if (refresh_grant_n_o) begin
			acked_reg <= 1'b0;
			if (enable_i && !refresh_request_n_i) begin
				wait_reg <= wait_reg + 8'h01;
				if (wait_reg >= delay_i) begin
					refresh_grant_n_o <= 1'b0;
					common_grant_n_o <= 1'b0;
					wait_reg <= 8'h00;
				end
			end
		end else begin
			wait_reg <= wait_reg + 8'h01;
			if (!grant_ack_n_i) acked_reg <= 1'b1;
			// Hazard: never hold the bus forever if acknowledge is missing
			if ((acked_reg && grant_ack_n_i) || wait_reg == 8'h20) begin
				refresh_grant_n_o <= 1'b1;
				common_grant_n_o <= 1'b1;
				wait_reg <= 8'h00;
			end
		end
	end
endmodule : refresh_arbiter_model

// ---- verification/tb_dram_parity_mmu_refresh.sv ----
module tb_dram_parity_mmu_refresh;
	import dram_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Stimulus, observation and bookkeeping
	// ------------------------------------------------------------
	localparam logic [23:1] USR_A = 23'h040000;
	localparam logic [23:1] EXP_A = 23'h100000;
	localparam logic [23:1] KERN_A = 23'h000010;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic processor_data_strobe_i, rd_wr_i, supervisor_access_bit_i, ram_space_i, bitmap_ref_i;
	logic dma_access_i, bus_master_select_n_i, upper_byte_parity_i, lower_byte_parity_i;
	logic page_status_bit0_i, page_referenced_flag_i, latched_page_write_enable_i;
	logic refresh_grant_n_i, common_grant_n_i, reg_wr_i, reg_rd_i, arb_en;
	logic [23:1] addr_i;
	logic [15:0] wr_data_i, ram_data_i, reg_wdata_i, reg_rdata_o, rd_data_o, q, s_rd;
	logic [1:0] byte_sel_i, s_par;
	logic [3:0] reg_addr_i, row_strobe_n_o;
	logic [7:0] refresh_row_o, arb_dly, s, r1, r2, r3;
	logic [2:0] s_ps;
	logic column_strobe_gate_n_o, addr_col_sel_o, xcvr_en_n_o, xcvr_dir_rd_o, refresh_addr_en_o;
	logic upper_byte_parity_o, lower_byte_parity_o, rd_data_valid_o, dtack_n_o, bus_error_n_o;
	logic level7_irq_n_o, parity_fault_n_o, translation_error_n_o, page_status_write_n_o;
	logic map_update_enable_o, new_page_status_bit0_o, new_page_referenced_flag_o;
	logic new_page_write_enable_o, refresh_request_n_o, grant_ack_n_o, w_all, w_drop;
	logic [15:0] wv [2] = '{16'h0301, 16'hFE00};
	logic [17:0] pv [2] = '{{16'h0001, 2'b00}, {16'h0100, 2'b00}};
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int t [6];
	int f1, f2, f3, w_ack, i;

	dram_parity_mmu_refresh dram_parity_mmu_refresh_inst (.clk_i, .rst_b_i,
		.processor_data_strobe_i, .rd_wr_i, .supervisor_access_bit_i, .addr_i, .ram_space_i,
		.bitmap_ref_i, .dma_access_i, .bus_master_select_n_i, .wr_data_i, .ram_data_i,
		.upper_byte_parity_i, .lower_byte_parity_i, .byte_sel_i, .page_status_bit0_i,
		.page_referenced_flag_i, .latched_page_write_enable_i, .refresh_grant_n_i,
		.common_grant_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.row_strobe_n_o, .column_strobe_gate_n_o, .addr_col_sel_o, .xcvr_en_n_o, .xcvr_dir_rd_o,
		.refresh_row_o, .refresh_addr_en_o, .upper_byte_parity_o, .lower_byte_parity_o,
		.rd_data_o, .rd_data_valid_o, .dtack_n_o, .bus_error_n_o, .level7_irq_n_o,
		.parity_fault_n_o, .translation_error_n_o, .page_status_write_n_o, .map_update_enable_o,
		.new_page_status_bit0_o, .new_page_referenced_flag_o, .new_page_write_enable_o,
		.refresh_request_n_o, .grant_ack_n_o);

	refresh_arbiter_model refresh_arbiter_model_inst (.clk_i, .rst_b_i, .enable_i(arb_en),
		.delay_i(arb_dly), .refresh_request_n_i(refresh_request_n_o),
		.grant_ack_n_i(grant_ack_n_o), .refresh_grant_n_o(refresh_grant_n_i),
		.common_grant_n_o(common_grant_n_i));

	// Clock and hang guard
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			$display("timeout reached");
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic pg(input logic [2:0] v);
		{page_status_bit0_i, page_referenced_flag_i, latched_page_write_enable_i} <= v;
	endtask : pg

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		{reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : reg_rd

	// One processor cycle; t[]: first row, select, column, ack, data, update cycle
	// s: 0 berr 1 mmu 2 parity 3 irq 4 column 5 status write 6 xcvr 7 xcvr misuse
	task automatic cpu(input logic rd, input logic sup, input logic [23:1] a,
		input logic [15:0] d);
		int n;
		@(posedge clk_i);
		{rd_wr_i, supervisor_access_bit_i, addr_i, wr_data_i} <= {rd, sup, a, d};
		processor_data_strobe_i <= 1'b1;
		t = '{default: 0};
		s = 8'h00;
		for (n = 1; n < 70 && (t[5] == 0 || n < t[5] + 3); n++) begin
			@(posedge clk_i);
			#1;
			if (row_strobe_n_o != 4'hF && t[0] == 0) t[0] = n;
			if (addr_col_sel_o && t[1] == 0) t[1] = n;
			if (!column_strobe_gate_n_o && t[2] == 0) t[2] = n;
			if (!dtack_n_o && t[3] == 0) t[3] = n;
			if (rd_data_valid_o && t[4] == 0) t[4] = n;
			if (rd_data_valid_o) s_rd = rd_data_o;
			if (map_update_enable_o && t[5] == 0) t[5] = n;
			if (!column_strobe_gate_n_o) s_par = {upper_byte_parity_o, lower_byte_parity_o};
			if (!page_status_write_n_o) s_ps = {new_page_referenced_flag_o,
				new_page_status_bit0_o, new_page_write_enable_o};
			s |= {!xcvr_en_n_o && (column_strobe_gate_n_o || a[21] || xcvr_dir_rd_o !== rd),
				!xcvr_en_n_o, !page_status_write_n_o, !column_strobe_gate_n_o,
				!level7_irq_n_o, !parity_fault_n_o, !translation_error_n_o, !bus_error_n_o};
		end
		@(posedge clk_i);
		processor_data_strobe_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : cpu

	// Observe one refresh from the falling edge of its request
	task automatic watch(output logic [7:0] row, output int at);
		logic g;
		{g, w_all, w_drop, row} = '0;
		w_ack = 0;
		do begin @(posedge clk_i); #1; end while (refresh_request_n_o !== 1'b1);
		do begin @(posedge clk_i); #1; end while (refresh_request_n_o === 1'b1);
		at = cyc;
		repeat (30) begin
			@(posedge clk_i);
			#1;
			if (!refresh_grant_n_i) g = 1'b1;
			if (!g && refresh_request_n_o) w_drop = 1'b1;
			if (!grant_ack_n_o) w_ack++;
			if (row_strobe_n_o === 4'h0) w_all = 1'b1;
			if (refresh_addr_en_o) row = refresh_row_o;
		end
	endtask : watch

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{processor_data_strobe_i, rd_wr_i, supervisor_access_bit_i, bitmap_ref_i} = '0;
		{dma_access_i, ram_space_i, bus_master_select_n_i, byte_sel_i} = 5'b01111;
		{addr_i, wr_data_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		{ram_data_i, upper_byte_parity_i, lower_byte_parity_i} = {16'hA5C3, 2'b11};
		pg(3'b111);
		{arb_en, arb_dly} = 9'h000;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("reset outputs", 16'h00FF, {8'h00, dtack_n_o, bus_error_n_o, level7_irq_n_o,
			parity_fault_n_o, translation_error_n_o, page_status_write_n_o,
			refresh_request_n_o, grant_ack_n_o});
		reg_rd(CTRL_ADDR, q);
		chk("control reset", {13'h0000, CTRL_RST}, q);
		reg_rd(4'hF, q);
		chk("unmapped read", 16'h0000, q);
		reg_wr(CTRL_ADDR, 16'h0003);
		reg_rd(CTRL_ADDR, q);
		chk("control readback", 16'h0003, q);
		$display("register test done");
		cpu(1'b1, 1'b1, USR_A, 16'h0000);
		chk("row to select", 16'(ADDR_SWITCH_CYC - ROW_STROBE_CYC), 16'(t[1] - t[0]));
		chk("row to column", 16'(COL_STROBE_CYC - ROW_STROBE_CYC), 16'(t[2] - t[0]));
		chk("row to ack", 16'(ACK_CYC - ROW_STROBE_CYC), 16'(t[3] - t[0]));
		chk("data not early", 1'b1, 1'(t[4] - t[0] >= DATA_VALID_CYC - ROW_STROBE_CYC));
		chk("read data", 16'hA5C3, s_rd);
		chk("column to update", 16'(TAP_120_CYC - COL_STROBE_CYC), 16'(t[5] - t[2]));
		chk("row released", 16'h000F, {12'h000, row_strobe_n_o});
		chk("transceiver use", 16'h0040, {8'h00, s} & 16'h00C4);
		chk("read new status", 16'h0005, {13'h0000, s_ps});
		cpu(1'b1, 1'b1, EXP_A, 16'h0000);
		chk("expansion transceiver", 1'b0, s[6]);
		bus_master_select_n_i <= 1'b0;
		cpu(1'b1, 1'b1, USR_A, 16'h0000);
		chk("no ack under master", 16'h0000, 16'(t[3]));
		bus_master_select_n_i <= 1'b1;
		for (i = 0; i < 2; i++) begin
			reg_wr(CTRL_ADDR, i == 0 ? 16'h0003 : 16'h0007);
			cpu(1'b0, 1'b1, USR_A, wv[i]);
			chk("write parity", 16'({~^wv[i][15:8], ~^wv[i][7:0]} ^ {2{i[0]}}), 16'(s_par));
			chk("write new status", 16'h0007, {13'h0000, s_ps});
		end
		$display("timing and write test done");
		for (i = 0; i < 2; i++) begin
			reg_wr(CTRL_ADDR, i == 0 ? 16'h0003 : 16'h0002);
			{ram_data_i, upper_byte_parity_i, lower_byte_parity_i} <= pv[i];
			cpu(1'b1, 1'b1, USR_A, 16'h0000);
			chk("parity fault", 1'b1, s[2]);
			chk("parity irq", 16'(i == 0), s[3]);
			reg_rd(STATUS_ADDR, q);
			chk("parity capture", 1'b1, q[STAT_PAR_BIT]);
			reg_wr(STATUS_ADDR, 16'h0007);
		end
		$display("parity test done");
		reg_wr(CTRL_ADDR, 16'h0003);
		pg(3'b001);
		cpu(1'b1, 1'b0, USR_A, 16'h0000);
		chk("fault bus and mmu error", 16'h0003, {14'h0, s[1:0]});
		chk("fault irq", 1'b1, s[3]);
		chk("fault column and status", 16'h0000, {14'h0, s[5:4]});
		chk("fault no parity", 1'b0, s[2]);
		reg_wr(STATUS_ADDR, 16'h0007);
		{ram_data_i, upper_byte_parity_i, lower_byte_parity_i} <= {16'hA5C3, 2'b11};
		cpu(1'b1, 1'b1, USR_A, 16'h0000);
		chk("supervisor no fault", 16'h0030, {8'h00, s} & 16'h0033);
		pg(3'b110);
		cpu(1'b0, 1'b0, USR_A, 16'h1234);
		chk("user bad write", 16'h0003, {8'h00, s} & 16'h0013);
		reg_wr(STATUS_ADDR, 16'h0007);
		pg(3'b111);
		cpu(1'b1, 1'b0, KERN_A, 16'h0000);
		chk("user kernel access", 1'b1, s[1]);
		reg_wr(STATUS_ADDR, 16'h0007);
		ram_space_i <= 1'b0;
		cpu(1'b1, 1'b0, USR_A, 16'h0000);
		chk("user non ram", 1'b1, s[0]);
		ram_space_i <= 1'b1;
		reg_wr(STATUS_ADDR, 16'h0007);
		cpu(1'b1, 1'b0, USR_A, 16'h0000);
		chk("user clean read", 16'h0004, {13'h0000, s_ps});
		chk("user clean errors", 16'h0000, {14'h0, s[1:0]});
		$display("management test done");
		arb_en <= 1'b1;
		watch(r1, f1);
		watch(r2, f2);
		chk("request spacing", 16'(REFRESH_DIV), 16'(f2 - f1));
		chk("row advance", {8'h00, r1 + 8'h01}, {8'h00, r2});
		chk("grant ack length", 16'h0002, 16'(w_ack));
		chk("all rows strobed", 1'b1, w_all);
		arb_dly <= 8'h0C;
		watch(r3, f3);
		chk("request held", 1'b0, w_drop);
		chk("row advance slow", {8'h00, r2 + 8'h01}, {8'h00, r3});
		$display("refresh test done");
		conclude();
	end
endmodule : tb_dram_parity_mmu_refresh
